// *** logic/piv_cfg.svh ***
`ifndef PIV_CFG_SVH
`define PIV_CFG_SVH

// Processor clock
`define PIV_CLK_PERIOD_NS     4

// Address request timing
`define PIV_ACK_TO_REQ_NS     2000
`define PIV_ACK_TO_REQ_CYC    ((`PIV_ACK_TO_REQ_NS + `PIV_CLK_PERIOD_NS - 1) \
                               / `PIV_CLK_PERIOD_NS)
`define PIV_REQ_WIDTH_NS      750
`define PIV_REQ_WIDTH_CYC     (`PIV_REQ_WIDTH_NS / `PIV_CLK_PERIOD_NS)

// Vector locations
`define PIV_VEC_RESTART       16'h0000
`define PIV_VEC_POWER         16'h001C
`define PIV_VEC_CONSOLE       16'h001E
`define PIV_VEC_LINE_ONE      16'h0002
`define PIV_VEC_LINE_TWO      16'h0006
`define PIV_VEC_RTC_CLOCK     16'h0018
`define PIV_VEC_RTC_SYNC      16'h001A
`define PIV_VEC_WORD_ALT      16'h0022
`define PIV_VEC_EOB_ALT       16'h0026
`define PIV_VEC_OFFSET        16'h0100

// Register offsets
`define PIV_REG_CTRL          8'h00
`define PIV_REG_STATUS        8'h04
`define PIV_REG_VECTOR        8'h08

// Control fields
`define PIV_CTRL_GIE          0
`define PIV_CTRL_OFFSET       1
`define PIV_CTRL_RELOCATE     2
`define PIV_CTRL_DUPLEX       3
`define PIV_CTRL_AUTOLOAD     4
`define PIV_CTRL_WIDTH        4
`define PIV_CTRL_RESET        4'h0

`endif

// *** logic/piv_pkg.sv ***
package piv_pkg;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ACK_WAIT,
      ST_ADDR_REQ,
      ST_SERVICE
   } piv_state_type;

   typedef enum logic [3:0] {
      SRC_NONE,
      SRC_POWER,
      SRC_CONSOLE,
      SRC_LINE_ONE,
      SRC_LINE_TWO,
      SRC_RTC_SYNC,
      SRC_RTC_CLOCK,
      SRC_EOB_A,
      SRC_WORD_A,
      SRC_EOB_B,
      SRC_WORD_B,
      SRC_CHAIN
   } piv_src_type;

endpackage

// *** logic/piv_sync.sv ***
`timescale 1ns/10ps

module piv_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             mclk_i,
   input  wire logic             rst_b_i,
   input  wire logic [WIDTH-1:0] async_i,
   input  wire logic [WIDTH-1:0] reset_val_i,
   output logic      [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;

   // Two-flop synchroniser; flops hold pin XOR idle level, so reset reads idle
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         stage1 <= '0;
         stage2 <= '0;
      end else begin
         stage1 <= async_i ^ reset_val_i;
         stage2 <= stage1;
      end
   end

   assign sync_o = stage2 ^ reset_val_i;

endmodule // piv_sync

// *** logic/piv_top.sv ***
`timescale 1ns/10ps
`include "piv_cfg.svh"

module piv_top (
   input  wire logic        mclk_i,
   input  wire logic        rst_b_i,
   // Classic Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Pins
   input  wire logic        power_low_i,
   input  wire logic        console_switch_i,
   input  wire logic        direct_line_one_b_i,
   input  wire logic        direct_line_two_b_i,
   input  wire logic        chained_request_b_i,
   input  wire logic [15:0] vector_bus_i,
   output logic             priority_pass_out_b_o,
   output logic             address_request_b_o,
   output logic             interrupt_ack_b_o,
   // Processor side, same clock
   input  wire logic        instr_boundary_i,
   input  wire logic        service_done_i,
   input  wire logic        trap_instruction_i,
   input  wire logic        halt_i,
   input  wire logic        rtc_clock_i,
   input  wire logic        rtc_sync_i,
   input  wire logic [1:0]  tty_word_i,
   input  wire logic [1:0]  tty_eob_i,
   output logic [15:0]      vector_addr_o,
   output logic             vector_valid_o,
   output logic             restart_o,
   output logic             autoload_o,
   output logic             run_mode_o
);

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   logic [20:0] pin_sync;
   logic        power_low;
   logic        console_sw;
   logic        line_one;
   logic        line_two;
   logic        chain_req;
   logic [15:0] vector_bus;

   piv_sync #(
      .WIDTH (21)
   ) u_sync (
      .mclk_i      (mclk_i),
      .rst_b_i     (rst_b_i),
      .async_i     ({power_low_i, console_switch_i, direct_line_one_b_i,
                     direct_line_two_b_i, chained_request_b_i,
                     vector_bus_i}),
      .reset_val_i (21'h07_0000),
      .sync_o      (pin_sync)
   );

   assign power_low  = pin_sync[20];
   assign console_sw = pin_sync[19];
   assign line_one   = ~pin_sync[18];
   assign line_two   = ~pin_sync[17];
   assign chain_req  = ~pin_sync[16];
   assign vector_bus = pin_sync[15:0];

   ////////////////////////////////////////////////////////////////////////
   // State

   piv_pkg::piv_state_type state;
   piv_pkg::piv_state_type next_state;
   piv_pkg::piv_src_type   src;
   piv_pkg::piv_src_type   next_src;

   logic [`PIV_CTRL_WIDTH-1:0] ctrl;
   logic [7:0]  pend;
   logic [7:0]  pend_set;
   logic [7:0]  pend_clr;
   logic        power_low_d;
   logic        console_sw_d;
   logic        autoload_req;
   logic [9:0]  cnt;
   logic [15:0] last_vector;

   wire gie      = ctrl[`PIV_CTRL_GIE];
   wire offset   = ctrl[`PIV_CTRL_OFFSET];
   wire relocate = ctrl[`PIV_CTRL_RELOCATE];
   wire duplex   = ctrl[`PIV_CTRL_DUPLEX];

   ////////////////////////////////////////////////////////////////////////
   // Pending sources
   // Bits: 0 power, 1 console/trap, 2 rtc sync, 3 rtc clock,
   //       4 eob a, 5 word a, 6 eob b, 7 word b

   wire power_fall   = power_low_d & ~power_low;
   wire power_rise   = power_low & ~power_low_d;
   wire console_rise = console_sw & ~console_sw_d & run_mode_o;

   assign pend_set = {tty_word_i[1] & duplex,
                      tty_eob_i[1] & duplex,
                      tty_word_i[0],
                      tty_eob_i[0],
                      rtc_clock_i,
                      rtc_sync_i,
                      console_rise | trap_instruction_i,
                      power_rise};

   ////////////////////////////////////////////////////////////////////////
   // Arbitration

   wire take = (state == piv_pkg::ST_IDLE) & instr_boundary_i & gie
               & run_mode_o & ~power_fall & ~autoload_req;

   // Fixed order; chain taken only when nothing above it waits
   assign next_src =
      pend[0]   ? piv_pkg::SRC_POWER     :
      pend[1]   ? piv_pkg::SRC_CONSOLE   :
      line_one  ? piv_pkg::SRC_LINE_ONE  :
      line_two  ? piv_pkg::SRC_LINE_TWO  :
      pend[2]   ? piv_pkg::SRC_RTC_SYNC  :
      pend[3]   ? piv_pkg::SRC_RTC_CLOCK :
      pend[4]   ? piv_pkg::SRC_EOB_A     :
      pend[5]   ? piv_pkg::SRC_WORD_A    :
      pend[6]   ? piv_pkg::SRC_EOB_B     :
      pend[7]   ? piv_pkg::SRC_WORD_B    :
      chain_req ? piv_pkg::SRC_CHAIN     :
                  piv_pkg::SRC_NONE;

   wire granted = take & (next_src != piv_pkg::SRC_NONE);

   assign pend_clr = {8{granted}} & {
      next_src == piv_pkg::SRC_WORD_B,
      next_src == piv_pkg::SRC_EOB_B,
      next_src == piv_pkg::SRC_WORD_A,
      next_src == piv_pkg::SRC_EOB_A,
      next_src == piv_pkg::SRC_RTC_CLOCK,
      next_src == piv_pkg::SRC_RTC_SYNC,
      next_src == piv_pkg::SRC_CONSOLE,
      next_src == piv_pkg::SRC_POWER};

   ////////////////////////////////////////////////////////////////////////
   // Vector generation

   wire [15:0] word_vec = relocate ? `PIV_VEC_WORD_ALT
                                   : `PIV_VEC_LINE_ONE;
   wire [15:0] eob_vec  = relocate ? `PIV_VEC_EOB_ALT
                                   : `PIV_VEC_LINE_TWO;

   // Second channel takes the other pair in full duplex
   wire [15:0] word_b_vec = relocate ? `PIV_VEC_LINE_ONE
                                     : `PIV_VEC_WORD_ALT;
   wire [15:0] eob_b_vec  = relocate ? `PIV_VEC_LINE_TWO
                                     : `PIV_VEC_EOB_ALT;

   wire [15:0] base_vec =
      (next_src == piv_pkg::SRC_POWER)     ? `PIV_VEC_POWER     :
      (next_src == piv_pkg::SRC_CONSOLE)   ? `PIV_VEC_CONSOLE   :
      (next_src == piv_pkg::SRC_LINE_ONE)  ? `PIV_VEC_LINE_ONE  :
      (next_src == piv_pkg::SRC_LINE_TWO)  ? `PIV_VEC_LINE_TWO  :
      (next_src == piv_pkg::SRC_RTC_SYNC)  ? `PIV_VEC_RTC_SYNC  :
      (next_src == piv_pkg::SRC_RTC_CLOCK) ? `PIV_VEC_RTC_CLOCK :
      (next_src == piv_pkg::SRC_EOB_A)     ? eob_vec            :
      (next_src == piv_pkg::SRC_WORD_A)    ? word_vec           :
      (next_src == piv_pkg::SRC_EOB_B)     ? eob_b_vec          :
      (next_src == piv_pkg::SRC_WORD_B)    ? word_b_vec         :
                                             `PIV_VEC_RESTART;

   wire [15:0] internal_vec = offset ? (base_vec | `PIV_VEC_OFFSET)
                                     : base_vec;

   ////////////////////////////////////////////////////////////////////////
   // Sequencer

   wire ack_wait_end = (cnt == 10'(`PIV_ACK_TO_REQ_CYC - 1));
   wire req_end      = (cnt == 10'(`PIV_REQ_WIDTH_CYC - 1));

   always_comb begin
      next_state = state;
      case (state)
         piv_pkg::ST_IDLE: begin
            if (granted) begin
               if (next_src == piv_pkg::SRC_CHAIN) begin
                  next_state = piv_pkg::ST_ACK_WAIT;
               end else begin
                  next_state = piv_pkg::ST_SERVICE;
               end
            end
         end
         piv_pkg::ST_ACK_WAIT: begin
            if (ack_wait_end) begin
               next_state = piv_pkg::ST_ADDR_REQ;
            end
         end
         piv_pkg::ST_ADDR_REQ: begin
            if (req_end) begin
               next_state = piv_pkg::ST_SERVICE;
            end
         end
         piv_pkg::ST_SERVICE: begin
            if (service_done_i) begin
               next_state = piv_pkg::ST_IDLE;
            end
         end
         default: begin
            next_state = piv_pkg::ST_IDLE;
         end
      endcase
   end

   // Processor blocks the chain while serving anything above it
   wire busy_above = (state != piv_pkg::ST_IDLE) & (src != piv_pkg::SRC_CHAIN);
   wire next_pass_b = busy_above | (|pend) | line_one | line_two
                      | granted & (next_src != piv_pkg::SRC_CHAIN);

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state <= piv_pkg::ST_IDLE;
         src   <= piv_pkg::SRC_NONE;
         cnt   <= 10'h000;
      end else if (power_fall | autoload_req) begin
         state <= piv_pkg::ST_IDLE;
         src   <= piv_pkg::SRC_NONE;
         cnt   <= 10'h000;
      end else begin
         state <= next_state;
         if (granted) begin
            src <= next_src;
         end
         cnt <= (next_state != state) ? 10'h000 : cnt + 10'h001;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pend         <= 8'h00;
         power_low_d  <= 1'b0;
         console_sw_d <= 1'b0;
      end else begin
         power_low_d  <= power_low;
         console_sw_d <= console_sw;
         if (power_fall) begin
            pend <= 8'h00;
         end else begin
            pend <= pend_set | (pend & ~pend_clr);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Processor and link outputs

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         vector_addr_o         <= `PIV_VEC_RESTART;
         vector_valid_o        <= 1'b0;
         restart_o             <= 1'b0;
         autoload_o            <= 1'b0;
         run_mode_o            <= 1'b0;
         interrupt_ack_b_o     <= 1'b1;
         address_request_b_o   <= 1'b1;
         priority_pass_out_b_o <= 1'b1;
         last_vector           <= `PIV_VEC_RESTART;
      end else begin
         vector_valid_o        <= 1'b0;
         restart_o             <= power_fall | autoload_req;
         autoload_o            <= autoload_req;
         priority_pass_out_b_o <= next_pass_b;
         interrupt_ack_b_o     <= (next_state == piv_pkg::ST_IDLE);
         address_request_b_o   <= (next_state != piv_pkg::ST_ADDR_REQ);
         if (power_fall | autoload_req) begin
            vector_addr_o         <= `PIV_VEC_RESTART;
            run_mode_o            <= 1'b1;
            interrupt_ack_b_o     <= 1'b1;
            address_request_b_o   <= 1'b1;
            priority_pass_out_b_o <= 1'b1;
         end else if (granted & (next_src != piv_pkg::SRC_CHAIN)) begin
            vector_addr_o  <= internal_vec;
            last_vector    <= internal_vec;
            vector_valid_o <= 1'b1;
         end else if ((state == piv_pkg::ST_ADDR_REQ) & req_end) begin
            vector_addr_o  <= vector_bus;
            last_vector    <= vector_bus;
            vector_valid_o <= 1'b1;
         end else if (halt_i) begin
            run_mode_o <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register slave

   wire        wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire        hit_ctrl = (wb_adr_i == `PIV_REG_CTRL);
   wire        hit_stat = (wb_adr_i == `PIV_REG_STATUS);
   wire        hit_vec  = (wb_adr_i == `PIV_REG_VECTOR);
   // Write lands at the ack edge, while the master still holds the request
   wire        ctrl_wr  = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & hit_ctrl
                          & wb_sel_i[0];
   wire [31:0] status_word = {16'h0000, 2'(state), 1'b0, run_mode_o,
                              chain_req, line_two, line_one, 1'b0, pend};
   wire [31:0] read_word =
      hit_ctrl ? {28'h000_0000, ctrl} :
      hit_stat ? status_word          :
      hit_vec  ? {16'h0000, last_vector} :
                 32'h0000_0000;

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wb_ack_o     <= 1'b0;
         wb_dat_o     <= 32'h0000_0000;
         ctrl         <= `PIV_CTRL_RESET;
         autoload_req <= 1'b0;
      end else begin
         wb_ack_o     <= wb_req;
         wb_dat_o     <= (wb_req & ~wb_we_i) ? read_word : 32'h0000_0000;
         autoload_req <= ctrl_wr & wb_dat_i[`PIV_CTRL_AUTOLOAD];
         if (ctrl_wr) begin
            ctrl <= wb_dat_i[`PIV_CTRL_WIDTH-1:0];
         end
      end
   end

endmodule // piv_top

// *** testbench/piv_top_properties.sv ***
`timescale 1ns/10ps
module piv_top_properties (
   input  wire logic        mclk_i,
   input  wire logic        rst_b_i,
   input  wire logic        instr_boundary_i,
   input  wire logic        service_done_i,
   input  wire logic        address_request_b_o,
   input  wire logic        interrupt_ack_b_o,
   input  wire logic        priority_pass_out_b_o,
   input  wire logic [15:0] vector_addr_o,
   input  wire logic        vector_valid_o,
   input  wire logic        restart_o,
   input  wire logic        autoload_o,
   input  wire logic        run_mode_o
);
   logic [9:0] low_cnt;

   // Length of the address request pulse
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         low_cnt <= 10'h000;
      end else if (!address_request_b_o) begin
         low_cnt <= low_cnt + 10'h001;
      end else begin
         low_cnt <= 10'h000;
      end
   end

   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);

   sequence s_self_grant;
      vector_valid_o && $fell(interrupt_ack_b_o);
   endsequence
   sequence s_chain_end;
      $rose(address_request_b_o);
   endsequence

   AST_SELF_NO_ADDR: assert property (s_self_grant |->
      address_request_b_o [*8]) else $error("address request on self vector");
   AST_SELF_VEC: assert property (s_self_grant |->
      vector_addr_o[15:9] == 7'h00 && (vector_addr_o & 16'hFEFF) inside
      {16'h001C, 16'h001E, 16'h0002, 16'h0006, 16'h0018, 16'h001A,
       16'h0022, 16'h0026}) else $error("bad internal vector");
   AST_SELF_BLOCKS: assert property (s_self_grant |->
      priority_pass_out_b_o) else $error("chain not blocked");
   AST_GRANT_CAUSE: assert property (vector_valid_o |->
      $past(instr_boundary_i) || $rose(address_request_b_o))
      else $error("vector without boundary");
   AST_RUN_GRANT: assert property ($fell(interrupt_ack_b_o) |->
      $past(run_mode_o)) else $error("grant outside run mode");
   AST_RESTART_ZERO: assert property (restart_o |->
      vector_addr_o == 16'h0000 && run_mode_o)
      else $error("restart not at zero");
   AST_AUTOLOAD: assert property (autoload_o |-> restart_o)
      else $error("autoload without restart");
   AST_REQ_WIDTH: assert property (s_chain_end |->
      low_cnt == 10'h0BB) else $error("address request width");
   AST_CHAIN_VEC: assert property (s_chain_end |->
      vector_valid_o && !interrupt_ack_b_o) else $error("chain vector late");
   AST_ACK_HOLD: assert property (!interrupt_ack_b_o && !service_done_i
      |=> !interrupt_ack_b_o || restart_o) else $error("ack dropped early");
endmodule // piv_top_properties

bind piv_top piv_top_properties chk_u (
   .mclk_i(mclk_i), .rst_b_i(rst_b_i), .instr_boundary_i(instr_boundary_i),
   .service_done_i(service_done_i), .address_request_b_o(address_request_b_o),
   .interrupt_ack_b_o(interrupt_ack_b_o), .run_mode_o(run_mode_o),
   .priority_pass_out_b_o(priority_pass_out_b_o), .restart_o(restart_o),
   .vector_addr_o(vector_addr_o), .vector_valid_o(vector_valid_o),
   .autoload_o(autoload_o)
);

// *** testbench/piv_chain_model.sv ***
`timescale 1ns/10ps
module piv_chain_model (
   input  wire logic        mclk_i,
   input  wire logic        rst_b_i,
   input  wire logic        req_i,
   input  wire logic [15:0] vec_i,
   input  wire logic        address_request_b_i,
   output logic             chained_request_b_o,
   output logic [15:0]      vector_bus_o
);
   logic        pend;
   logic        ar_q;
   logic [15:0] held;
   logic [15:0] last;

   // Request held until the vector has been taken
   assign chained_request_b_o = ~pend;
   // Vector only while asked, a changed pattern otherwise
   assign vector_bus_o = address_request_b_i ? ~last : held;

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pend <= 1'b0;
         ar_q <= 1'b1;
         held <= 16'h0000;
         last <= 16'h0000;
      end else begin
         ar_q <= address_request_b_i;
         if (req_i) begin
            pend <= 1'b1;
            held <= vec_i;
         end else if (address_request_b_i && !ar_q) begin
            pend <= 1'b0;
         end
         if (!address_request_b_i) begin
            last <= held;
         end
      end
   end
endmodule // piv_chain_model

// *** testbench/piv_tb_top.sv ***
`timescale 1ns/10ps
module piv_tb_top;
   logic        mclk_i = 1'b0, rst_b_i = 1'b0, cyc = 1'b0, stb = 1'b0;
   logic        we = 1'b0, pwr = 1'b0, csw = 1'b0, l1_b = 1'b1, l2_b = 1'b1;
   logic        bnd = 1'b0, sdone = 1'b0, trap = 1'b0, rtck = 1'b0;
   logic        rtsy = 1'b0, mreq = 1'b0, hlt = 1'b0;
   logic [1:0]  word = 2'h0, end_of_block = 2'h0;
   logic [7:0]  adr = 8'h00;
   logic [15:0] mvec = 16'h0000, vbus, vec;
   logic [31:0] wdat = 32'h0000_0000, rdat, q;
   logic        ack, ch_b, pass_b, ar_b, ia_b, vval, rso, auto, run;
   int          miscompares = 0, num_checks = 0, cycles = 0;
   // Control value, source, expected vector
   logic [31:0] rows [10] = '{
      32'h0100_0002,
      32'h0101_0006,
      32'h0500_0022,
      32'h0501_0026,
      32'h0900_0002,
      32'h0902_0022,
      32'h0903_0026,
      32'h0704_0102,
      32'h0305_011E,
      32'h0306_0118
   };

   always #2 mclk_i = ~mclk_i;

   piv_top dut_u (
      .mclk_i(mclk_i), .rst_b_i(rst_b_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .power_low_i(pwr),
      .console_switch_i(csw), .direct_line_one_b_i(l1_b),
      .direct_line_two_b_i(l2_b), .chained_request_b_i(ch_b),
      .vector_bus_i(vbus), .priority_pass_out_b_o(pass_b),
      .address_request_b_o(ar_b), .interrupt_ack_b_o(ia_b),
      .instr_boundary_i(bnd), .service_done_i(sdone),
      .trap_instruction_i(trap), .halt_i(hlt), .rtc_clock_i(rtck),
      .rtc_sync_i(rtsy), .tty_word_i(word), .tty_eob_i(end_of_block),
      .vector_addr_o(vec), .vector_valid_o(vval), .restart_o(rso),
      .autoload_o(auto), .run_mode_o(run)
   );

   piv_chain_model peer_u (
      .mclk_i(mclk_i), .rst_b_i(rst_b_i), .req_i(mreq), .vec_i(mvec),
      .address_request_b_i(ar_b), .chained_request_b_o(ch_b),
      .vector_bus_o(vbus)
   );

   ////////////////////////////////////////
   task stop_test;
      if (miscompares == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   task tick(input int n);
      repeat (n) @(posedge mclk_i);
   endtask

   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge mclk_i);
      while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task await(input int k);
      do @(posedge mclk_i);
      while (!(k == 0 ? vval === 1'b1 : k == 1 ? rso === 1'b1 : ia_b === 1'b1));
   endtask

   task pulse_bnd;
      @(posedge mclk_i);
      bnd <= 1'b1;
      @(posedge mclk_i);
      bnd <= 1'b0;
   endtask

   task irq(input logic [15:0] e, input logic ch);
      pulse_bnd;
      await(0);
      chk({16'h0000, vec}, {16'h0000, e});
      chk({31'h0000_0000, pass_b}, {31'h0000_0000, !ch});
      @(posedge mclk_i);
      sdone <= 1'b1;
      @(posedge mclk_i);
      sdone <= 1'b0;
      await(2);
   endtask

   task idle_bnd;
      pulse_bnd;
      tick(4);
      chk({31'h0000_0000, ia_b}, 32'h0000_0001);
   endtask

   task fire(input logic [7:0] s);
      @(posedge mclk_i);
      case (s)
         8'h00: word <= 2'h1;
         8'h01: end_of_block <= 2'h1;
         8'h02: word <= 2'h2;
         8'h03: end_of_block <= 2'h2;
         8'h04: l1_b <= 1'b0;
         8'h05: trap <= 1'b1;
         default: rtck <= 1'b1;
      endcase
      @(posedge mclk_i);
      word <= 2'h0;
      end_of_block <= 2'h0;
      trap <= 1'b0;
      rtck <= 1'b0;
      tick(3);
   endtask

   ////////////////////////////////////////
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         $display("unexpected at %0t: timeout", $time);
         stop_test;
      end
   end

   initial begin
      tick(16);
      rst_b_i <= 1'b1;
      tick(1);
      chk({13'h0000, ia_b, ar_b, run, vec}, {13'h0000, 3'h6, 16'h0000});
      wb(1'b0, 8'h00, 32'h0000_0000);
      chk(q, 32'h0000_0000);
      wb(1'b0, 8'h0C, 32'h0000_0000);
      chk(q, 32'h0000_0000);
      l1_b <= 1'b0;
      idle_bnd;
      wb(1'b1, 8'h00, 32'h0000_0010);
      await(1);
      chk({14'h0000, auto, run, vec}, {14'h0000, 2'h3, 16'h0000});
      idle_bnd;
      wb(1'b1, 8'h00, 32'h0000_0005);
      l2_b <= 1'b0;
      csw <= 1'b1;
      tick(4);
      csw <= 1'b0;
      tick(3);
      irq(16'h001E, 1'b0);
      irq(16'h0002, 1'b0);
      l1_b <= 1'b1;
      tick(3);
      irq(16'h0006, 1'b0);
      l2_b <= 1'b1;
      rtck <= 1'b1;
      rtsy <= 1'b1;
      tick(1);
      rtck <= 1'b0;
      rtsy <= 1'b0;
      tick(3);
      irq(16'h001A, 1'b0);
      irq(16'h0018, 1'b0);
      foreach (rows[i]) begin
         wb(1'b1, 8'h00, {24'h00_0000, rows[i][31:24]});
         fire(rows[i][23:16]);
         irq(rows[i][15:0], 1'b0);
         l1_b <= 1'b1;
      end
      pwr <= 1'b1;
      tick(4);
      irq(16'h011C, 1'b0);
      pwr <= 1'b0;
      await(1);
      chk({14'h0000, auto, run, vec}, {14'h0000, 2'h1, 16'h0000});
      hlt <= 1'b1;
      tick(1);
      hlt <= 1'b0;
      csw <= 1'b1;
      tick(4);
      csw <= 1'b0;
      tick(3);
      wb(1'b0, 8'h04, 32'h0000_0000);
      chk(q & 32'h0000_1002, 32'h0000_0000);
      wb(1'b1, 8'h00, 32'h0000_0010);
      await(1);
      wb(1'b1, 8'h00, 32'h0000_0005);
      mvec <= 16'h4A52;
      mreq <= 1'b1;
      l2_b <= 1'b0;
      tick(1);
      mreq <= 1'b0;
      tick(3);
      irq(16'h0006, 1'b0);
      l2_b <= 1'b1;
      tick(3);
      irq(16'h4A52, 1'b1);
      wb(1'b0, 8'h08, 32'h0000_0000);
      chk(q, 32'h0000_4A52);
      stop_test;
   end
endmodule // piv_tb_top
